// ### ahad_adapter_decode.sv
// Host address decode, interrupt routing and configuration header.
// Assumes host requests are synchronous to clk_in; channel interrupt
// pins are asynchronous and are synchronised here.
//
// Summary of operation
// - Fixed mode decodes the four standard command and control banks on ISA, the first two on PCI.
// - Fixed mode drives lines 14, 15, and on ISA also 11 or alt, 10 or alt.
// - The second control register at 3F7h and 377h is not decoded.
// - Legacy mode uses register banks only, PIO data, configurable bases.
// - Fixed mode uses block registers with fixed addresses and lines.
// - Native mode decodes from base registers and shares one interrupt.
// - Descriptor-driven mode hides command and control blocks from host.
// - ISA decoder adapter does PIO only, with bus timing, no setup.
// - ISA decoder implements the fixed register set per channel, except the second control register.
// - PCI fixed mode offers exactly primary and secondary channels.
// - PCI native mode offers one or two channels.
// - Class code shows mode abilities; software may switch channel modes.
// - A subset of the type 00h header is implemented.
// - Reserved configuration fields read zero and ignore writes.
// - Five base registers sit at offsets 10h through 20h.
// - Base registers 0 to 3 have bit 0 fixed at one.
// - Fixed mode ignores base writes and decodes default addresses.
// - With I/O enable clear, nothing is claimed and interrupts float.
// - Interface bits 0 and 2 pick mode; bits 1 and 3 show switchability.
`timescale 1ns/1ps
`default_nettype none
module ahad_adapter_decode #(
  parameter logic ISA_KIND = 1'b0,
  parameter int NATIVE_CHANNELS = 2,
  parameter logic [3:0] ISA_CHAN_MASK = 4'hf,
  parameter logic PRI_SWITCHABLE = 1'b1,
  parameter logic SEC_SWITCHABLE = 1'b1,
  parameter logic PRI_NATIVE_RESET = 1'b0,
  parameter logic SEC_NATIVE_RESET = 1'b0,
  parameter logic [1:0] TERT_ALT = 2'h0,
  parameter logic [1:0] QUAT_ALT = 2'h0,
  // Identification values below are arbitrary.
  parameter logic [31:0] DEVICE_IDENT = 32'h0001_0002,
  parameter logic [15:0] SUBSYS_IDENT = 16'h0003,
  parameter logic [7:0] REVISION = 8'h01
) (
  input wire logic clk_in, // Host bus clock, 40 MHz.
  input wire logic reset_in, // Synchronous reset, active high.
  input wire logic cfg_req_in, // Configuration access strobe.
  input wire logic cfg_wr_in, // Configuration write when high.
  input wire logic [7:0] cfg_addr_in, // Configuration byte address.
  input wire logic [3:0] cfg_be_in, // Byte enables.
  input wire logic [31:0] cfg_wdata_in, // Configuration write data.
  output logic cfg_ack_out, // Access done, one cycle pulse.
  output logic [31:0] cfg_rdata_out, // Configuration read data.
  input wire logic io_req_in, // Host I/O access strobe.
  input wire logic [15:0] io_addr_in, // Host I/O address.
  output logic io_claim_out, // Access claimed, one cycle pulse.
  output ahad_pkg::ahad_hit_s io_hit_out, // Claimed channel and register.
  input wire logic legacy_sel_in, // ISA jumper: legacy addresses.
  input wire ahad_pkg::ahad_legacy_s legacy_base_in, // Jumper bases.
  input wire logic desc_mode_in, // Descriptor-driven mode on.
  input wire logic [3:0] chan_irq_in, // Channel interrupt pins.
  output logic [5:0] irq_line_out, // Fixed interrupt line levels.
  output logic [5:0] irq_line_oe_out, // Fixed line drive enables.
  output logic shared_irq_out, // Shared native interrupt level.
  output logic shared_irq_oe_out // Shared line drive enable.
);
  import ahad_pkg::*;

  logic io_en_reg;
  logic pri_native_reg;
  logic sec_native_reg;
  logic [7:0] int_line_reg;
  logic cfg_ack_reg;
  logic [31:0] cfg_rdata_reg;
  logic [31:0] cfg_rdata_next;
  logic [31:0] bar_val [NUM_BARS];
  logic [NUM_BARS-1:0] bar_wr;
  logic [NUM_BARS-1:0] bar_lock;
  logic cfg_write;
  logic io_en;
  logic [7:0] prog_if;
  ahad_mode_e mode [4];
  logic [3:0] chan_live;
  logic [3:0] regs_on;
  logic [3:0][15:0] cmd_base;
  logic [3:0][15:0] ctl_base;
  logic claim_next;
  ahad_hit_s hit_next;
  logic io_claim_reg;
  ahad_hit_s io_hit_reg;
  logic [3:0] irq_meta_reg;
  logic [3:0] irq_sync_reg;
  logic [5:0] line_next;
  logic [5:0] line_oe_next;
  logic shared_next;
  logic shared_oe_next;
  logic [5:0] line_reg;
  logic [5:0] line_oe_reg;
  logic shared_reg;
  logic shared_oe_reg;

  // Command block hit: eight byte window on an eight byte boundary.
  function automatic logic cmd_hit(input logic [15:0] a,
    input logic [15:0] base);
    cmd_hit = a[15:3] == base[15:3];
  endfunction : cmd_hit

  // Control hit: only offset two of the control dword is decoded.
  function automatic logic ctl_hit(input logic [15:0] a,
    input logic [15:0] base);
    ctl_hit = (a[15:2] == base[15:2]) && (a[1:0] == CTRL_REG_OFS);
  endfunction : ctl_hit

  // Interrupt line of a channel in fixed mode.
  function automatic logic [2:0] fixed_line(input int c);
    logic [1:0] alt;
    alt = (c == 2) ? TERT_ALT : QUAT_ALT;
    if (c == 0)
      fixed_line = IRQ_L14;
    else if (c == 1)
      fixed_line = IRQ_L15;
    else if (alt == ALT_L12)
      fixed_line = IRQ_L12;
    else if (alt == ALT_L9)
      fixed_line = IRQ_L9;
    else
      fixed_line = (c == 2) ? IRQ_L11 : IRQ_L10;
  endfunction : fixed_line

  // The ISA decoder has no configuration space; writes are dropped.
  assign cfg_write = cfg_req_in && cfg_wr_in && !ISA_KIND;
  assign io_en = ISA_KIND ? 1'b1 : io_en_reg;
  assign prog_if = {4'h0, SEC_SWITCHABLE, sec_native_reg,
    PRI_SWITCHABLE, pri_native_reg};

  // Command register: only the I/O space enable is kept.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      io_en_reg <= 1'b0;
    else if (cfg_write && cfg_addr_in[7:2] == OFS_COMMAND[7:2] &&
      cfg_be_in[0])
      io_en_reg <= cfg_wdata_in[CMD_IO_EN];
  end

  // Channel mode bits; only switchable channels take writes.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pri_native_reg <= PRI_NATIVE_RESET;
      sec_native_reg <= SEC_NATIVE_RESET;
    end
    else if (cfg_write && cfg_addr_in[7:2] == OFS_CLASS[7:2] &&
      cfg_be_in[1])
    begin
      if (PRI_SWITCHABLE)
        pri_native_reg <= cfg_wdata_in[8 + PI_PRI_NATIVE];
      if (SEC_SWITCHABLE)
        sec_native_reg <= cfg_wdata_in[8 + PI_SEC_NATIVE];
    end
  end

  // Interrupt line scratch byte, stored for software only.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      int_line_reg <= 8'h00;
    else if (cfg_write && cfg_addr_in[7:2] == OFS_INT_LINE[7:2] &&
      cfg_be_in[0])
      int_line_reg <= cfg_wdata_in[7:0];
  end

  // Five base registers; the four channel ones are locked to defaults while their channel is fixed.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BARS; gi++)
    begin : g_bar
      assign bar_wr[gi] = cfg_write &&
        cfg_addr_in[7:2] == OFS_BAR0[7:2] + 6'(gi);
      assign bar_lock[gi] = (gi < 2) ? !pri_native_reg :
        (gi < 4) ? !sec_native_reg : 1'b0;
      ahad_bar_reg #(
        .RESET_VAL(BAR_RESET[gi])
      ) u_bar (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_in(bar_wr[gi]),
        .be_in(cfg_be_in),
        .wdata_in(cfg_wdata_in),
        .lock_in(bar_lock[gi]),
        .value_out(bar_val[gi])
      );
    end
  endgenerate

  // Read data mux; unlisted and reserved dwords read zero.
  always_comb
  begin
    cfg_rdata_next = 32'h0000_0000;
    if (!ISA_KIND)
    begin
      case (cfg_addr_in)
        OFS_IDENT: cfg_rdata_next = DEVICE_IDENT;
        OFS_COMMAND: cfg_rdata_next = {31'h0, io_en_reg};
        OFS_CLASS: cfg_rdata_next = {CLASS_BASE, CLASS_SUB, prog_if,
          REVISION};
        OFS_BAR0: cfg_rdata_next = bar_val[0];
        OFS_BAR1: cfg_rdata_next = bar_val[1];
        OFS_BAR2: cfg_rdata_next = bar_val[2];
        OFS_BAR3: cfg_rdata_next = bar_val[3];
        OFS_BAR4: cfg_rdata_next = bar_val[4];
        OFS_SUBSYS: cfg_rdata_next = {SUBSYS_IDENT, 16'h0000};
        OFS_INT_LINE: cfg_rdata_next = {24'h00_0000, int_line_reg};
        default: cfg_rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Configuration answer one cycle after the strobe.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      cfg_ack_reg <= 1'b0;
      cfg_rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      cfg_ack_reg <= cfg_req_in;
      if (cfg_req_in && !cfg_wr_in)
        cfg_rdata_reg <= cfg_rdata_next;
    end
  end

  // Per-channel mode, bases and enables.
  always_comb
  begin
    for (int c = 0; c < 4; c++)
    begin
      mode[c] = MODE_COMPAT;
      cmd_base[c] = COMPAT_CMD[c];
      ctl_base[c] = COMPAT_CTL[c];
      if (ISA_KIND)
      begin
        // Register decode only: all data is PIO through the data port.
        chan_live[c] = ISA_CHAN_MASK[c];
        if (legacy_sel_in && c < 2)
        begin
          mode[c] = MODE_LEGACY;
          cmd_base[c] = legacy_base_in.cmd_base[c];
          ctl_base[c] = legacy_base_in.ctl_base[c];
        end
      end
      else
      begin
        chan_live[c] = c < 2;
        if (c < 2)
        begin
          cmd_base[c] = bar_val[2 * c][15:0];
          ctl_base[c] = bar_val[2 * c + 1][15:0];
          if (c == 0 ? pri_native_reg : sec_native_reg)
          begin
            mode[c] = MODE_NATIVE;
            if (c == 1 && NATIVE_CHANNELS < 2)
              chan_live[c] = 1'b0;
          end
        end
      end
      if (desc_mode_in)
        mode[c] = MODE_DESCR;
      chan_live[c] = chan_live[c] && io_en;
      regs_on[c] = chan_live[c] && mode[c] != MODE_DESCR;
    end
  end

  // Address decode; the lowest matching channel wins.
  always_comb
  begin
    claim_next = 1'b0;
    hit_next = '0;
    for (int c = 3; c >= 0; c--)
    begin
      if (io_req_in && regs_on[c] && cmd_hit(io_addr_in, cmd_base[c]))
      begin
        claim_next = 1'b1;
        hit_next = '{chan: 2'(c), is_ctrl: 1'b0,
          reg_idx: io_addr_in[2:0]};
      end
      else if (io_req_in && regs_on[c] &&
        ctl_hit(io_addr_in, ctl_base[c]))
      begin
        claim_next = 1'b1;
        hit_next = '{chan: 2'(c), is_ctrl: 1'b1,
          reg_idx: io_addr_in[2:0]};
      end
    end
  end

  // Claim is registered; unmatched accesses are left alone.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      io_claim_reg <= 1'b0;
      io_hit_reg <= '0;
    end
    else
    begin
      io_claim_reg <= claim_next;
      if (claim_next)
        io_hit_reg <= hit_next;
    end
  end

  // Two-stage synchroniser for the channel interrupt pins.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      irq_meta_reg <= 4'h0;
      irq_sync_reg <= 4'h0;
    end
    else
    begin
      irq_meta_reg <= chan_irq_in;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  // Route each channel to its fixed line or the shared native line.
  always_comb
  begin
    line_next = 6'h00;
    line_oe_next = 6'h00;
    shared_next = 1'b0;
    shared_oe_next = 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      if (chan_live[c])
      begin
        if (mode[c] == MODE_COMPAT || mode[c] == MODE_LEGACY)
        begin
          line_oe_next[fixed_line(c)] = 1'b1;
          line_next[fixed_line(c)] = line_next[fixed_line(c)] |
            irq_sync_reg[c];
        end
        else
        begin
          shared_oe_next = 1'b1;
          shared_next = shared_next | irq_sync_reg[c];
        end
      end
    end
  end

  // Interrupt outputs come from flip-flops.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      line_reg <= 6'h00;
      line_oe_reg <= 6'h00;
      shared_reg <= 1'b0;
      shared_oe_reg <= 1'b0;
    end
    else
    begin
      line_reg <= line_next;
      line_oe_reg <= line_oe_next;
      shared_reg <= shared_next;
      shared_oe_reg <= shared_oe_next;
    end
  end

  assign cfg_ack_out = cfg_ack_reg;
  assign cfg_rdata_out = cfg_rdata_reg;
  assign io_claim_out = io_claim_reg;
  assign io_hit_out = io_hit_reg;
  assign irq_line_out = line_reg;
  assign irq_line_oe_out = line_oe_reg;
  assign shared_irq_out = shared_reg;
  assign shared_irq_oe_out = shared_oe_reg;

  claim_needs_req_a: assert property (@(posedge clk_in) disable iff (reset_in)
    io_claim_out |-> $past(io_req_in))
    else $error("claim without a request");
  disabled_quiet_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !io_en ##1 !io_en |-> !io_claim_out && irq_line_oe_out == 6'h00 &&
    !shared_irq_oe_out)
    else $error("disabled adapter claimed or drove an interrupt");
  no_second_ctrl_a: assert property (@(posedge clk_in) disable iff (reset_in)
    io_req_in && (io_addr_in == 16'h03f7 || io_addr_in == 16'h0377) &&
    !ISA_KIND |=> !io_claim_out)
    else $error("second control address was claimed");
  descr_hidden_a: assert property (@(posedge clk_in) disable iff (reset_in)
    desc_mode_in |=> !io_claim_out)
    else $error("block registers claimed in descriptor mode");
  bar_io_bit_a: assert property (@(posedge clk_in) disable iff (reset_in)
    bar_val[0][0] && bar_val[1][0] && bar_val[2][0] && bar_val[3][0])
    else $error("base register lost its I/O space bit");
  rsvd_reads_zero_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    cfg_req_in && !cfg_wr_in && cfg_addr_in == OFS_RSVD |=>
    cfg_ack_out && cfg_rdata_out == 32'h0000_0000)
    else $error("reserved dword read nonzero");
  compat_pri_irq_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !ISA_KIND && io_en && !pri_native_reg && !desc_mode_in &&
    chan_irq_in[0] ##1 $stable(chan_irq_in[0]) && io_en &&
    !pri_native_reg ##1 $stable(chan_irq_in[0]) && io_en &&
    !pri_native_reg && !desc_mode_in |=>
    irq_line_out[IRQ_L14] && irq_line_oe_out[IRQ_L14])
    else $error("primary interrupt did not reach line 14");
  compat_pri_bank_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    !ISA_KIND && io_en && !pri_native_reg && !desc_mode_in && io_req_in &&
    io_addr_in == 16'h01f3 |=> io_claim_out && io_hit_out.chan == 2'h0 &&
    !io_hit_out.is_ctrl && io_hit_out.reg_idx == 3'h3)
    else $error("primary command bank not decoded");
  native_shared_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !ISA_KIND && io_en && pri_native_reg |=>
    !irq_line_oe_out[IRQ_L14])
    else $error("native channel drove a fixed line");
endmodule : ahad_adapter_decode
`default_nettype wire

// ### ahad_pkg.sv
// Shared constants and carrier types for the adapter decode block.
// Assumes a single host bus clock and a synchronous reset.
package ahad_pkg;

  // Configuration header dword offsets (byte addresses).
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_CLASS = 8'h08;
  localparam logic [7:0] OFS_BAR0 = 8'h10;
  localparam logic [7:0] OFS_BAR1 = 8'h14;
  localparam logic [7:0] OFS_BAR2 = 8'h18;
  localparam logic [7:0] OFS_BAR3 = 8'h1c;
  localparam logic [7:0] OFS_BAR4 = 8'h20;
  localparam logic [7:0] OFS_RSVD = 8'h24;
  localparam logic [7:0] OFS_SUBSYS = 8'h2c;
  localparam logic [7:0] OFS_INT_LINE = 8'h3c;
  localparam int NUM_BARS = 5;

  // Class code bytes: mass storage, ATA controller.
  localparam logic [7:0] CLASS_BASE = 8'h01;
  localparam logic [7:0] CLASS_SUB = 8'h01;

  // Programming interface bit positions.
  localparam int PI_PRI_NATIVE = 0;
  localparam int PI_PRI_SWITCH = 1;
  localparam int PI_SEC_NATIVE = 2;
  localparam int PI_SEC_SWITCH = 3;

  // Command register I/O space enable bit.
  localparam int CMD_IO_EN = 0;

  // Base address register reset values and writable bits.
  localparam logic [31:0] BAR_RESET [NUM_BARS] = '{
    32'h0000_01f1, 32'h0000_03f5, 32'h0000_0171, 32'h0000_0375,
    32'h0000_0000};
  localparam logic [31:0] BAR_RW_MASK = 32'h0000_fff8;

  // Fixed banks: command block bases and control dword bases.
  localparam logic [15:0] COMPAT_CMD [4] = '{
    16'h01f0, 16'h0170, 16'h01e8, 16'h0168};
  localparam logic [15:0] COMPAT_CTL [4] = '{
    16'h03f4, 16'h0374, 16'h03ec, 16'h036c};
  // Only the register at offset two of the control dword is decoded.
  localparam logic [1:0] CTRL_REG_OFS = 2'h2;

  // Interrupt line output positions.
  localparam int NUM_IRQ_LINES = 6;
  localparam logic [2:0] IRQ_L14 = 3'h0;
  localparam logic [2:0] IRQ_L15 = 3'h1;
  localparam logic [2:0] IRQ_L11 = 3'h2;
  localparam logic [2:0] IRQ_L10 = 3'h3;
  localparam logic [2:0] IRQ_L12 = 3'h4;
  localparam logic [2:0] IRQ_L9 = 3'h5;

  // Alternate interrupt choice for the third and fourth channel.
  localparam logic [1:0] ALT_NONE = 2'h0;
  localparam logic [1:0] ALT_L12 = 2'h1;
  localparam logic [1:0] ALT_L9 = 2'h2;

  typedef enum logic [1:0] {
    MODE_LEGACY,
    MODE_COMPAT,
    MODE_NATIVE,
    MODE_DESCR
  } ahad_mode_e;

  // Result of a claimed host I/O access.
  typedef struct packed {
    logic [1:0] chan;
    logic is_ctrl;
    logic [2:0] reg_idx;
  } ahad_hit_s;

  // Jumper-set bank addresses for the first two channels in legacy mode.
  typedef struct packed {
    logic [1:0][15:0] cmd_base;
    logic [1:0][15:0] ctl_base;
  } ahad_legacy_s;

endpackage : ahad_pkg

// ### ahad_bar_reg.sv
// One base address register of the configuration header.
// Assumes byte-lane write strobes arrive on the host bus clock.
`timescale 1ns/1ps
`default_nettype none
module ahad_bar_reg #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
  input wire logic clk_in, // Host bus clock.
  input wire logic reset_in, // Synchronous reset, active high.
  input wire logic wr_in, // Write strobe for this register.
  input wire logic [3:0] be_in, // Byte enables.
  input wire logic [31:0] wdata_in, // Write data.
  input wire logic lock_in, // Fixed-address mode in force.
  output logic [31:0] value_out // Value seen by reads and decode.
);
  import ahad_pkg::*;

  logic [31:0] bar_reg;
  logic [31:0] lane_mask;

  // Expand byte enables to bit lanes, keep only writable bits.
  always_comb
  begin
    lane_mask = {{8{be_in[3]}}, {8{be_in[2]}}, {8{be_in[1]}},
      {8{be_in[0]}}} & BAR_RW_MASK;
  end

  // Writes are dropped while the address is fixed.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      bar_reg <= RESET_VAL;
    else if (wr_in && !lock_in)
      bar_reg <= (bar_reg & ~lane_mask) | (wdata_in & lane_mask);
  end

  // A locked register always shows and decodes its default.
  assign value_out = lock_in ? RESET_VAL : bar_reg;

  locked_default_a: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_in && lock_in |=> $stable(bar_reg))
    else $error("locked base register left its default");
endmodule : ahad_bar_reg
`default_nettype wire

// ### ahad_host_model.sv
// Behavioural host bus and configuration software for the decode block.
// Assumes requests are launched 1 ns after a clk_in rising edge.
`timescale 1ns/1ps
`default_nettype none
module ahad_host_model (
  input wire logic clk_in, // Host bus clock.
  input wire logic cfg_ack_in, // Configuration access done.
  input wire logic [31:0] cfg_rdata_in, // Configuration read data.
  input wire logic io_claim_in, // I/O access claimed.
  input wire ahad_pkg::ahad_hit_s io_hit_in, // Claimed register.
  output logic cfg_req_out, // Configuration access strobe.
  output logic cfg_wr_out, // Write when high.
  output logic [7:0] cfg_addr_out, // Configuration byte address.
  output logic [3:0] cfg_be_out, // Byte enables.
  output logic [31:0] cfg_wdata_out, // Write data.
  output logic io_req_out, // I/O access strobe.
  output logic [15:0] io_addr_out // I/O address.
);
  import ahad_pkg::*;

  // Idle bus at time zero.
  initial
  begin
    cfg_req_out = 1'b0;
    cfg_wr_out = 1'b0;
    cfg_addr_out = 8'hff;
    cfg_be_out = 4'h0;
    cfg_wdata_out = 32'h0;
    io_req_out = 1'b0;
    io_addr_out = 16'hffff;
  end

  // One configuration cycle; released write, address and data lines flip so nothing stale lingers.
  task automatic cfg(input logic wr, input logic [7:0] ad,
    input logic [3:0] be, input logic [31:0] d,
    output logic [31:0] q, output logic ack);
    @(posedge clk_in);
    #1;
    cfg_req_out = 1'b1;
    cfg_wr_out = wr;
    cfg_addr_out = ad;
    cfg_be_out = be;
    cfg_wdata_out = d;
    @(posedge clk_in);
    #1;
    cfg_req_out = 1'b0;
    cfg_wr_out = ~wr;
    cfg_addr_out = ~ad;
    cfg_wdata_out = ~d;
    ack = cfg_ack_in;
    q = cfg_rdata_in;
  endtask : cfg

  // One host I/O cycle, reporting the claim and the decoded register.
  task automatic io(input logic [15:0] ad, output logic hit,
    output ahad_hit_s h);
    @(posedge clk_in);
    #1;
    io_req_out = 1'b1;
    io_addr_out = ad;
    @(posedge clk_in);
    #1;
    io_req_out = 1'b0;
    io_addr_out = ~ad;
    hit = io_claim_in;
    h = io_hit_in;
  endtask : io
endmodule : ahad_host_model
`default_nettype wire

// ### ahad_adapter_decode_tb.sv
// Self-checking bench for the adapter decode block, PCI and ISA kinds.
// Assumes the host model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
  begin \
    cmp_count++; \
    if ((e) !== (g)) \
    begin \
      errors++; \
      $display("[FAIL] %s exp %h got %h", n, e, g); \
    end \
  end
module ahad_adapter_decode_tb;
  import ahad_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic desc_mode = 1'b0;
  logic [3:0] chan_irq = 4'h0;
  logic legacy_sel = 1'b0;
  ahad_legacy_s lb = 64'h0310_0300_0318_0308;
  wire logic cfg_req, cfg_wr, cfg_ack, io_req, io_claim, sh_irq, sh_oe;
  wire logic [7:0] cfg_addr;
  wire logic [3:0] cfg_be;
  wire logic [31:0] cfg_wdata, cfg_rdata;
  wire logic [15:0] io_addr;
  wire logic [5:0] irq, irq_oe;
  wire logic [5:0] isa_irq, isa_oe;
  wire logic isa_claim;
  ahad_hit_s isa_hit;
  ahad_hit_s hit;
  ahad_hit_s h;
  logic [31:0] q;
  logic a;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  // Clock at 40 MHz.
  always #12.5 clk_in = ~clk_in;

  ahad_adapter_decode ahad_adapter_decode_inst (.clk_in(clk_in),
    .reset_in(reset_in), .cfg_req_in(cfg_req), .cfg_wr_in(cfg_wr),
    .cfg_addr_in(cfg_addr), .cfg_be_in(cfg_be), .cfg_wdata_in(cfg_wdata),
    .cfg_ack_out(cfg_ack), .cfg_rdata_out(cfg_rdata), .io_req_in(io_req),
    .io_addr_in(io_addr), .io_claim_out(io_claim), .io_hit_out(hit),
    .legacy_sel_in(1'b0), .legacy_base_in('0), .desc_mode_in(desc_mode),
    .chan_irq_in(chan_irq), .irq_line_out(irq), .irq_line_oe_out(irq_oe),
    .shared_irq_out(sh_irq), .shared_irq_oe_out(sh_oe));

  ahad_host_model ahad_host_model_inst (.clk_in(clk_in),
    .cfg_ack_in(cfg_ack), .cfg_rdata_in(cfg_rdata),
    .io_claim_in(io_claim), .io_hit_in(hit), .cfg_req_out(cfg_req),
    .cfg_wr_out(cfg_wr), .cfg_addr_out(cfg_addr), .cfg_be_out(cfg_be),
    .cfg_wdata_out(cfg_wdata), .io_req_out(io_req),
    .io_addr_out(io_addr));

  // Second copy as an ISA decoder, third channel on its alternate line.
  ahad_adapter_decode #(.ISA_KIND(1'b1), .TERT_ALT(ALT_L12))
    ahad_adapter_decode_isa_inst (.clk_in(clk_in), .reset_in(reset_in),
    .cfg_req_in(cfg_req), .cfg_wr_in(cfg_wr), .cfg_addr_in(cfg_addr),
    .cfg_be_in(cfg_be), .cfg_wdata_in(cfg_wdata), .cfg_ack_out(),
    .cfg_rdata_out(), .io_req_in(io_req), .io_addr_in(io_addr),
    .io_claim_out(isa_claim), .io_hit_out(isa_hit),
    .legacy_sel_in(legacy_sel), .legacy_base_in(lb),
    .desc_mode_in(desc_mode), .chan_irq_in(chan_irq),
    .irq_line_out(isa_irq), .irq_line_oe_out(isa_oe),
    .shared_irq_out(), .shared_irq_oe_out());

  // Read a dword and compare it and its acknowledge.
  task automatic rdc(input string n, input logic [7:0] ad,
    input logic [31:0] e);
    ahad_host_model_inst.cfg(1'b0, ad, 4'hf, 32'h0, q, a);
    `CHK("ack", 1'b1, a)
    `CHK(n, e, q)
  endtask : rdc

  // Write a dword with the given lanes.
  task automatic wrc(input logic [7:0] ad, input logic [3:0] be,
    input logic [31:0] d);
    ahad_host_model_inst.cfg(1'b1, ad, be, d, q, a);
  endtask : wrc

  // Issue an I/O access; compare claim and channel with control flag.
  task automatic ioc(input string n, input logic [15:0] ad,
    input logic e, input logic [2:0] eh);
    ahad_host_model_inst.io(ad, a, h);
    `CHK(n, e, a)
    if (e)
    begin
      `CHK(n, eh, {h.chan, h.is_ctrl})
      `CHK("reg_idx", ad[2:0], h.reg_idx)
    end
  endtask : ioc

  // Let interrupt pins travel through the synchroniser.
  task automatic pins(input logic [3:0] v);
    chan_irq = v;
    repeat (5) @(posedge clk_in);
    #1;
  endtask : pins

  // Header defaults, reserved space and the scratch byte.
  task automatic t_header;
    rdc("bar0", OFS_BAR0, 32'h0000_01f1);
    rdc("bar1", OFS_BAR1, 32'h0000_03f5);
    rdc("bar2", OFS_BAR2, 32'h0000_0171);
    rdc("bar3", OFS_BAR3, 32'h0000_0375);
    rdc("bar4", OFS_BAR4, 32'h0);
    rdc("class", OFS_CLASS, {CLASS_BASE, CLASS_SUB, 16'h0a01});
    wrc(OFS_RSVD, 4'hf, 32'hffff_ffff);
    rdc("rsvd", OFS_RSVD, 32'h0);
    rdc("unlisted", 8'h0c, 32'h0);
    wrc(OFS_INT_LINE, 4'h1, 32'h5a);
    rdc("intline", OFS_INT_LINE, 32'h5a);
  endtask : t_header

  // With I/O disabled nothing is claimed and lines float.
  task automatic t_io_off;
    ioc("off", 16'h01f0, 1'b0, 3'h0);
    pins(4'h3);
    `CHK("off_oe", 6'h0, irq_oe)
    pins(4'h0);
  endtask : t_io_off

  // Fixed banks, lines and locked base registers.
  task automatic t_compat;
    wrc(OFS_COMMAND, 4'h1, 32'h1);
    ioc("p_cmd", 16'h01f3, 1'b1, 3'h0);
    ioc("p_ctl", 16'h03f6, 1'b1, 3'h1);
    ioc("s_cmd", 16'h0177, 1'b1, 3'h2);
    ioc("s_ctl", 16'h0376, 1'b1, 3'h3);
    ioc("p_f7", 16'h03f7, 1'b0, 3'h0);
    ioc("s_f7", 16'h0377, 1'b0, 3'h0);
    ioc("t_cmd", 16'h01e8, 1'b0, 3'h0);
    ioc("none", 16'h0100, 1'b0, 3'h0);
    wrc(OFS_BAR0, 4'hf, 32'h0000_1000);
    rdc("lock", OFS_BAR0, 32'h0000_01f1);
    ioc("dflt", 16'h01f0, 1'b1, 3'h0);
    pins(4'h3);
    `CHK("lines", 6'h03, irq)
    `CHK("lines_oe", 6'h03, irq_oe)
    `CHK("sh_oe", 1'b0, sh_oe)
    pins(4'h0);
    `CHK("lines_low", 6'h00, irq)
  endtask : t_compat

  // Switch both channels to native and decode from base registers.
  task automatic t_native;
    wrc(OFS_CLASS, 4'h2, 32'h0000_0500);
    rdc("pi", OFS_CLASS, {CLASS_BASE, CLASS_SUB, 16'h0f01});
    wrc(OFS_BAR0, 4'hf, 32'h0000_1007);
    wrc(OFS_BAR1, 4'hf, 32'h0000_2000);
    wrc(OFS_BAR2, 4'hf, 32'h0000_3000);
    rdc("bar0n", OFS_BAR0, 32'h0000_1001);
    rdc("bar1n", OFS_BAR1, 32'h0000_2005);
    ioc("n_cmd", 16'h1005, 1'b1, 3'h0);
    ioc("n_ctl", 16'h2006, 1'b1, 3'h1);
    ioc("n_ctl0", 16'h2004, 1'b0, 3'h0);
    ioc("n_y", 16'h3001, 1'b1, 3'h2);
    ioc("n_old", 16'h01f3, 1'b0, 3'h0);
    pins(4'h2);
    `CHK("shared", 1'b1, sh_irq)
    `CHK("shared_oe", 1'b1, sh_oe)
    `CHK("fixed_oe", 6'h00, irq_oe)
    pins(4'h0);
    desc_mode = 1'b1;
    ioc("desc", 16'h1005, 1'b0, 3'h0);
    desc_mode = 1'b0;
    wrc(OFS_COMMAND, 4'h1, 32'h0);
    ioc("off2", 16'h1005, 1'b0, 3'h0);
  endtask : t_native

  // ISA decoder: third and fourth fixed banks, all four lines, then jumper bases.
  task automatic t_isa;
    ahad_host_model_inst.io(16'h01ee, a, h);
    `CHK("isa_t", 7'h66, {isa_claim, isa_hit})
    ahad_host_model_inst.io(16'h036e, a, h);
    `CHK("isa_q", 7'h7e, {isa_claim, isa_hit})
    pins(4'hf);
    `CHK("isa_lines", 6'h1b, isa_irq)
    `CHK("isa_oe", 6'h1b, isa_oe)
    pins(4'h0);
    legacy_sel = 1'b1;
    ahad_host_model_inst.io(16'h0305, a, h);
    `CHK("leg_cmd", 7'h45, {isa_claim, isa_hit})
    ahad_host_model_inst.io(16'h01f3, a, h);
    `CHK("leg_old", 1'b0, isa_claim)
    legacy_sel = 1'b0;
  endtask : t_isa

  // Print the counts and the verdict, then stop.
  task automatic summarize;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // Cut a hang short.
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      summarize();
    end
  end

  // Reset for eight cycles, then run every scenario.
  initial
  begin
    repeat (8) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    t_header();
    t_io_off();
    t_compat();
    t_native();
    t_isa();
    summarize();
  end
endmodule : ahad_adapter_decode_tb
`default_nettype wire
